// ===== test_trigger_io_video_embed.sv
// self-checking testbench for the trigger embed block
`timescale 1ns/1ps
module test_trigger_io_video_embed;
	logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic [3:0] GPI_IN, GPO_OUT, g, as;
	logic [1:0] VID_LINE_START, TX_VALID, RX_VALID;
	logic [1:0][10:0] VID_LINE, RX_LINE;
	logic [1:0][7:0] TX_DATA, RX_DATA;
	logic e;
	int n_mismatch = 0;
	int checks = 0;
	logic [11:0] addr [6] = '{12'h03C, 12'h048, 12'h0BC, 12'h0C8, 12'h3F8, 12'h3FC};
	logic [7:0] rstv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h32};
	logic [7:0] pols [4] = '{8'h00, 8'hF0, 8'h0F, 8'hA5};
	trigger_io_video_embed i_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .GPI_IN(GPI_IN), .GPO_OUT(GPO_OUT), .VID_LINE_START(VID_LINE_START),
		.VID_LINE(VID_LINE), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .RX_VALID(RX_VALID),
		.RX_LINE(RX_LINE), .RX_DATA(RX_DATA));
	video_far_side i_far (.clk(CLK), .gpi_in(GPI_IN), .line_start(VID_LINE_START),
		.line(VID_LINE), .rx_valid(RX_VALID), .rx_line(RX_LINE), .rx_data(RX_DATA));
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	// --------------------------------
	// tasks
	// --------------------------------
	function automatic logic [7:0] word(input logic [3:0] d);
		return {~d[0], d[3] ^ d[2], ~(d[1] ^ d[3]), ^d, d};
	endfunction
	task report_and_stop();
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge CLK);
			if (PREADY === 1'b1) break;
		end
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (n == 20) begin
			n_mismatch++;
			report_and_stop();
		end else begin
			@(posedge CLK);
		end
	endtask
	initial begin
		RST = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h000;
		PWDATA = 32'h0;
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		for (int i = 0; i < 6; i++) begin
			apb(0, addr[i], 0);
			chk("reset", rd, {24'h0, rstv[i]});
			apb(1, addr[i], 32'hC3 ^ i);
			apb(0, addr[i], 0);
			chk("readback", rd, 32'hC3 ^ i);
		end
		apb(0, 12'h200, 0);
		chk("unmapped", {rd[30:0], er}, 32'h1);
		apb(1, 12'h048, 32'h80);
		for (int p = 0; p < 4; p++) begin
			apb(1, 12'h03C, pols[p]);
			g = 4'hE ^ 4'(p);
			i_far.press(g);
			@(posedge CLK);
			i_far.start_line(0, 11'd13);
			@(posedge CLK);
			as = g ~^ pols[p][3:0];
			chk("tx", {TX_VALID, TX_DATA[0]}, {2'b01, word(as ~^ pols[p][7:4])});
		end
		// second channel keeps polarity C1h and insertion on from the readback pass
		i_far.start_line(1, 11'd13);
		@(posedge CLK);
		chk("tx b", {TX_VALID, TX_DATA[1]}, {2'b10, word((g ~^ 4'h1) ~^ 4'hC)});
		i_far.start_line(0, 11'd12);
		@(posedge CLK);
		chk("off line", TX_VALID, 0);
		apb(1, 12'h100, 12);
		i_far.start_line(0, 11'd12);
		@(posedge CLK);
		chk("new line", TX_VALID, 1);
		apb(1, 12'h048, 0);
		i_far.start_line(0, 11'd12);
		@(posedge CLK);
		chk("tx off", TX_VALID, 0);
		apb(1, 12'h03C, 0);
		apb(1, 12'h0BC, 0);
		i_far.rx_word(0, 11'd12, word(4'b1010));
		i_far.rx_word(1, 11'd13, word(4'b1100));
		for (int c = 0; c < 10; c++) begin
			apb(1, 12'h3F8, {2{4'(c)}});
			apb(1, 12'h3FC, {2{4'(c)}});
			repeat (3) @(posedge CLK);
			// bits 3:0 channel one states, 7:4 channel two states
			e = 1'(c < 8 ? 8'h35 >> c : 8'h00);
			chk("out12", GPO_OUT[1:0], {2{e}});
			chk("out34", GPO_OUT[3:2], {2{e}});
		end
		apb(1, 12'h3F8, 0);
		i_far.rx_word(0, 11'd12, word(4'b1011) ^ 8'h10);
		repeat (2) @(posedge CLK);
		chk("bad word", GPO_OUT[0], 1);
		apb(0, 12'h108, 0);
		chk("error flag", rd[12], 1);
		chk("rx state", rd[11:4], 8'h35);
		report_and_stop();
	end
endmodule

// ===== trigger_chan_if.sv
// per-channel link between the register block and the stream encoder and decoder
`timescale 1ns/1ps
interface trigger_chan_if #(parameter int LW = 11);
	logic [LW-1:0] embed_line;
	logic tx_on;
	logic [3:0] tx_pol;
	logic [3:0] trig_now;
	logic line_start;
	logic [LW-1:0] line;
	logic tx_valid;
	logic [7:0] tx_data;
	logic rx_valid;
	logic [LW-1:0] rx_line;
	logic [7:0] rx_data;
	logic [3:0] rx_trig;
	logic bad_word;

	modport ctl (
		output embed_line, tx_on, tx_pol, trig_now, line_start, line,
		output rx_valid, rx_line, rx_data,
		input tx_valid, tx_data, rx_trig, bad_word
	);
	modport enc (
		input embed_line, tx_on, tx_pol, trig_now, line_start, line,
		output tx_valid, tx_data
	);
	modport dec (
		input embed_line, tx_pol, rx_valid, rx_line, rx_data,
		output rx_trig, bad_word
	);
endinterface

// ===== trigger_decoder.sv
// recovers trigger states from the embedding line of incoming video
`timescale 1ns/1ps
module trigger_decoder
	import trigger_io_pkg::*;
#(
	parameter int LW = 11
) (
	input wire logic clk,
	input wire logic rst,
	trigger_chan_if.dec ch
);
	import trigger_io_pkg::*;

	typedef struct packed {
		logic [3:0] rx_trig;
		logic bad_word;
	} dec_state_t;

	dec_state_t cur;
	dec_state_t next_cur;

	always_comb begin
		next_cur = cur;
		next_cur.bad_word = 1'b0;
		if (ch.rx_valid && ch.rx_line == ch.embed_line) begin
			// a damaged word leaves the previous states untouched
			if (ch.rx_data[7:4] == trig_check(ch.rx_data[3:0])) begin
				next_cur.rx_trig = ch.rx_data[3:0] ~^ ch.tx_pol;
			end else begin
				next_cur.bad_word = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign ch.rx_trig = cur.rx_trig;
	assign ch.bad_word = cur.bad_word;
endmodule

// ===== trigger_encoder.sv
// places one check-protected trigger word on the embedding line of outgoing video
`timescale 1ns/1ps
module trigger_encoder
	import trigger_io_pkg::*;
#(
	parameter int LW = 11
) (
	input wire logic clk,
	input wire logic rst,
	trigger_chan_if.enc ch
);
	import trigger_io_pkg::*;

	typedef struct packed {
		logic tx_valid;
		logic [7:0] tx_data;
	} enc_state_t;

	enc_state_t cur;
	enc_state_t next_cur;
	logic [3:0] coded;

	always_comb begin
		// live state at the embed line keeps the change in its own frame
		coded = ch.trig_now ~^ ch.tx_pol;
		next_cur = cur;
		next_cur.tx_valid = 1'b0;
		if (ch.line_start && ch.line == ch.embed_line && ch.tx_on) begin
			next_cur.tx_valid = 1'b1;
			next_cur.tx_data = {trig_check(coded), coded};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign ch.tx_valid = cur.tx_valid;
	assign ch.tx_data = cur.tx_data;
endmodule

// ===== trigger_io_pkg.sv
// constants, types and the check code shared by the trigger embed design
//
// Behaviour
// - route low nibble, first register: codes 0-3 channel one, 4-7 channel two
// - route high nibble, first register: same eight codes choose output two source
// - second route register: low nibble output three, high nibble output four
// - valid trigger data on the set line drives outputs routed from it
// - asserted output is a high level; outside pull-up needed, open collector
// - inputs assert by closing to ground, then get encoded on the video line
// - embedding line defaults to 13 for every format, and is software settable
// - polarity bits 0-3 set input assertion polarity; zero is active low default
// - polarity bits 4-7 set polarity written into video; zero active low default
// - insertion control bit 7 enables trigger data into that channel's video
// - trigger state goes out in the very frame in which the input changed
// - check code travels with the data; corrupted words are rejected on receive
package trigger_io_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam int IDX_W = 10;
	localparam logic [9:0] IDX_POL_A = 10'h00F;
	localparam logic [9:0] IDX_INS_A = 10'h012;
	localparam logic [9:0] IDX_POL_B = 10'h02F;
	localparam logic [9:0] IDX_INS_B = 10'h032;
	localparam logic [9:0] IDX_ROUTE_12 = 10'h0FE;
	localparam logic [9:0] IDX_ROUTE_34 = 10'h0FF;
	localparam logic [9:0] IDX_LINE_A = 10'h040;
	localparam logic [9:0] IDX_LINE_B = 10'h041;
	localparam logic [9:0] IDX_STATUS = 10'h042;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int INS_TX_BIT = 7;
	localparam int POL_RX_LSB = 0;
	localparam int POL_TX_LSB = 4;
	localparam int STAT_GPI_LSB = 0;
	localparam int STAT_RXA_LSB = 4;
	localparam int STAT_RXB_LSB = 8;
	localparam int STAT_ERR_LSB = 12;
	localparam int RST_LINE = 13;
	localparam logic [7:0] RST_POL = 8'h00;
	localparam logic [7:0] RST_INS = 8'h00;
	localparam logic [7:0] RST_ROUTE_12 = 8'h10;
	localparam logic [7:0] RST_ROUTE_34 = 8'h32;
	localparam int TRIG_N = 4;
	localparam int CHAN_N = 2;

	// ----------------------------------------------------------------
	// bus slave states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BUS_IDLE = 2'h0,
		BUS_ACK = 2'h1
	} bus_state_t;

	// error check nibble sent beside the trigger nibble
	function automatic logic [3:0] trig_check(input logic [3:0] d);
		return {~d[0], d[3] ^ d[2], ~(d[1] ^ d[3]), ^d};
	endfunction

endpackage

// ===== trigger_io_video_embed.sv
// top: register slave on APB, input capture, two video channels, output routing
`timescale 1ns/1ps
module trigger_io_video_embed
	import trigger_io_pkg::*;
#(
	parameter int LINE_W = 11
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [3:0] GPI_IN,
	output logic [3:0] GPO_OUT,
	input wire logic [1:0] VID_LINE_START,
	input wire logic [1:0][LINE_W-1:0] VID_LINE,
	output logic [1:0] TX_VALID,
	output logic [1:0][7:0] TX_DATA,
	input wire logic [1:0] RX_VALID,
	input wire logic [1:0][LINE_W-1:0] RX_LINE,
	input wire logic [1:0][7:0] RX_DATA
);
	import trigger_io_pkg::*;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (LINE_W < 5 || LINE_W > 16) begin : g_bad_width
		$error("LINE_W must lie between 5 and 16");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		bus_state_t bus;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [1:0][7:0] pol;
		logic [1:0][7:0] ins;
		logic [1:0][LINE_W-1:0] line;
		logic [1:0][7:0] route;
		logic [3:0] gpi;
		logic [3:0] gpo;
		logic [1:0] rx_err;
	} top_state_t;

	top_state_t cur;
	top_state_t next_cur;
	logic [1:0][3:0] rx_trig;
	logic [1:0] bad_word;
	logic [1:0] tx_valid;
	logic [1:0][7:0] tx_data;
	logic [IDX_W-1:0] idx;

	assign idx = PADDR[11:2];

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// undefined codes give a released output
	function automatic logic route_pick(input logic [3:0] code, input logic [1:0][3:0] rx);
		logic bit_out;
		bit_out = 1'b0;
		if (!code[3]) begin
			bit_out = rx[code[2]][code[1:0]];
		end
		return bit_out;
	endfunction

	// bit 32 flags a mapped index
	function automatic logic [32:0] reg_read(input logic [IDX_W-1:0] i, input top_state_t s);
		logic [32:0] r;
		r = '0;
		case (i)
			IDX_POL_A: r = {1'b1, 24'h000000, s.pol[0]};
			IDX_INS_A: r = {1'b1, 24'h000000, s.ins[0]};
			IDX_POL_B: r = {1'b1, 24'h000000, s.pol[1]};
			IDX_INS_B: r = {1'b1, 24'h000000, s.ins[1]};
			IDX_ROUTE_12: r = {1'b1, 24'h000000, s.route[0]};
			IDX_ROUTE_34: r = {1'b1, 24'h000000, s.route[1]};
			IDX_LINE_A: r = {1'b1, 32'(s.line[0])};
			IDX_LINE_B: r = {1'b1, 32'(s.line[1])};
			IDX_STATUS: begin
				r[32] = 1'b1;
				r[STAT_GPI_LSB +: 4] = s.gpi;
				r[STAT_RXA_LSB +: 4] = rx_trig[0];
				r[STAT_RXB_LSB +: 4] = rx_trig[1];
				r[STAT_ERR_LSB +: 2] = s.rx_err;
			end
			default: r = '0;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// channels
	// ----------------------------------------------------------------
	for (genvar c = 0; c < CHAN_N; c++) begin : g_chan
		trigger_chan_if #(.LW(LINE_W)) chan ();

		// pin equals its polarity bit when asserted; low closure is the default
		assign chan.trig_now = cur.gpi ~^ cur.pol[c][POL_RX_LSB +: 4];
		assign chan.embed_line = cur.line[c];
		assign chan.tx_on = cur.ins[c][INS_TX_BIT];
		assign chan.tx_pol = cur.pol[c][POL_TX_LSB +: 4];
		assign chan.line_start = VID_LINE_START[c];
		assign chan.line = VID_LINE[c];
		assign chan.rx_valid = RX_VALID[c];
		assign chan.rx_line = RX_LINE[c];
		assign chan.rx_data = RX_DATA[c];
		assign rx_trig[c] = chan.rx_trig;
		assign bad_word[c] = chan.bad_word;
		assign tx_valid[c] = chan.tx_valid;
		assign tx_data[c] = chan.tx_data;

		trigger_encoder #(.LW(LINE_W)) u_enc (
			.clk(CLK),
			.rst(RST),
			.ch(chan.enc)
		);

		trigger_decoder #(.LW(LINE_W)) u_dec (
			.clk(CLK),
			.rst(RST),
			.ch(chan.dec)
		);
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [32:0] rd;
		logic take_wr;
		rd = reg_read(idx, cur);
		take_wr = 1'b0;
		next_cur = cur;
		next_cur.gpi = GPI_IN;

		// output routing; high level means asserted
		for (int k = 0; k < TRIG_N; k++) begin
			next_cur.gpo[k] = route_pick(cur.route[k / 2][(k % 2) * 4 +: 4], rx_trig);
		end

		// zero-wait-state slave: answer follows the setup cycle
		case (cur.bus)
			BUS_IDLE: begin
				next_cur.pready = 1'b0;
				next_cur.pslverr = 1'b0;
				if (PSEL && !PENABLE) begin
					next_cur.bus = BUS_ACK;
					next_cur.pready = 1'b1;
					next_cur.pslverr = ~rd[32];
					next_cur.prdata = PWRITE ? 32'h00000000 : rd[31:0];
				end
			end
			BUS_ACK: begin
				next_cur.bus = BUS_IDLE;
				next_cur.pready = 1'b0;
				next_cur.pslverr = 1'b0;
				take_wr = PSEL && PENABLE && PWRITE && !cur.pslverr;
			end
			default: begin
				next_cur.bus = BUS_IDLE;
				next_cur.pready = 1'b0;
				next_cur.pslverr = 1'b0;
			end
		endcase

		if (take_wr) begin
			case (idx)
				IDX_POL_A: next_cur.pol[0] = PWDATA[7:0];
				IDX_INS_A: next_cur.ins[0] = PWDATA[7:0];
				IDX_POL_B: next_cur.pol[1] = PWDATA[7:0];
				IDX_INS_B: next_cur.ins[1] = PWDATA[7:0];
				IDX_ROUTE_12: next_cur.route[0] = PWDATA[7:0];
				IDX_ROUTE_34: next_cur.route[1] = PWDATA[7:0];
				IDX_LINE_A: next_cur.line[0] = PWDATA[LINE_W-1:0];
				IDX_LINE_B: next_cur.line[1] = PWDATA[LINE_W-1:0];
				IDX_STATUS: next_cur.rx_err = cur.rx_err & ~PWDATA[STAT_ERR_LSB +: 2];
				default: next_cur.rx_err = next_cur.rx_err;
			endcase
		end

		// a rejected word in the clearing cycle still leaves its flag set
		next_cur.rx_err = next_cur.rx_err | bad_word;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			cur.bus <= BUS_IDLE;
			cur.pready <= 1'b0;
			cur.pslverr <= 1'b0;
			cur.prdata <= 32'h00000000;
			cur.pol <= {RST_POL, RST_POL};
			cur.ins <= {RST_INS, RST_INS};
			cur.line <= {LINE_W'(RST_LINE), LINE_W'(RST_LINE)};
			cur.route <= {RST_ROUTE_34, RST_ROUTE_12};
			cur.gpi <= 4'hF;
			cur.gpo <= 4'h0;
			cur.rx_err <= 2'h0;
		end else begin
			cur <= next_cur;
		end
	end

	assign PRDATA = cur.prdata;
	assign PREADY = cur.pready;
	assign PSLVERR = cur.pslverr;
	assign GPO_OUT = cur.gpo;
	assign TX_VALID = tx_valid;
	assign TX_DATA = tx_data;
endmodule

// ===== trigger_io_video_embed_chk.sv
// assertion checker bound to the trigger embed top
`timescale 1ns/1ps
module trigger_io_video_embed_chk (
	input wire logic CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [3:0] GPO_OUT,
	input wire logic [1:0] VID_LINE_START,
	input wire logic [1:0] TX_VALID,
	input wire logic [1:0][7:0] TX_DATA
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	logic [7:0] r12;
	// shadow of the first route register, to judge undefined codes
	always_ff @(posedge CLK) begin
		if (RST)
			r12 <= 8'h10;
		else if (PSEL && PENABLE && PREADY && PWRITE && PADDR[11:2] == 10'h0FE)
			r12 <= PWDATA[7:0];
	end
	AST_SETUP_ANSWER: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
		else $error("ready not one cycle after setup");
	AST_READY_CAUSE: assert property (PREADY |-> PSEL && PENABLE)
		else $error("ready outside an access");
	AST_REFUSE_ZERO: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
		else $error("refused access carries data");
	AST_TX_CODE_A: assert property (TX_VALID[0] |-> TX_DATA[0][7:4] ==
		{~TX_DATA[0][0], TX_DATA[0][3] ^ TX_DATA[0][2], ~(TX_DATA[0][1] ^ TX_DATA[0][3]),
		^TX_DATA[0][3:0]}) else $error("bad check nibble");
	AST_TX_ON_START: assert property ((TX_VALID & ~$past(VID_LINE_START)) == 2'h0)
		else $error("word without line start");
	AST_RESET_QUIET: assert property ($fell(RST) |-> GPO_OUT == 4'h0 && TX_VALID == 2'h0)
		else $error("outputs active after reset");
	AST_UNDEF_OUT1: assert property (r12[3] && $past(r12[3]) && $past(r12[3], 2)
		|-> !GPO_OUT[0]) else $error("undefined code drives output one");
	AST_UNDEF_OUT2: assert property (r12[7] && $past(r12[7]) && $past(r12[7], 2)
		|-> !GPO_OUT[1]) else $error("undefined code drives output two");
endmodule

bind trigger_io_video_embed trigger_io_video_embed_chk i_chk (.CLK(CLK), .RST(RST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .GPO_OUT(GPO_OUT),
	.VID_LINE_START(VID_LINE_START), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA));

// ===== video_far_side.sv
// far side model: contact closures and video line timing
`timescale 1ns/1ps
module video_far_side #(
	parameter int LW = 11
) (
	input wire logic clk,
	output logic [3:0] gpi_in,
	output logic [1:0] line_start,
	output logic [1:0][LW-1:0] line,
	output logic [1:0] rx_valid,
	output logic [1:0][LW-1:0] rx_line,
	output logic [1:0][7:0] rx_data
);
	initial begin
		gpi_in = 4'hF;
		line_start = 2'h0;
		line = '0;
		rx_valid = 2'h0;
		rx_line = '0;
		rx_data = '0;
	end
	task press(input logic [3:0] v);
		gpi_in <= v; // closed contact pulls to ground
	endtask
	// numbers invert when released, so a stale value is never mistaken
	task start_line(input int c, input logic [LW-1:0] n);
		line_start[c] <= 1'b1;
		line[c] <= n;
		@(posedge clk);
		line_start[c] <= 1'b0;
		line[c] <= ~n;
	endtask
	task rx_word(input int c, input logic [LW-1:0] n, input logic [7:0] w);
		rx_valid[c] <= 1'b1;
		rx_line[c] <= n;
		rx_data[c] <= w;
		@(posedge clk);
		rx_valid[c] <= 1'b0;
		rx_line[c] <= ~n;
		rx_data[c] <= ~w;
	endtask
endmodule
